//--- logic/smrc_pkg.sv
// Package with the register map, control fields and sample timing of the mode/rate control block.
package smrc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h0d;
    localparam logic [7:0] ADDR_MODE_RATE_CTRL  = 8'h2a;
    localparam logic [7:0] CTRL_RESET           = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED       = 8'h00;

    // ------------------------------------------------------------------
    // Output data addresses walked by a burst read
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_X_MSB    = 8'h01;
    localparam logic [7:0] ADDR_Y_MSB    = 8'h03;
    localparam logic [7:0] ADDR_Z_MSB    = 8'h05;
    localparam logic [7:0] ADDR_Z_LSB    = 8'h06;
    localparam logic [7:0] ADDR_STEP_ONE = 8'h01;
    localparam logic [7:0] ADDR_STEP_TWO = 8'h02;
    localparam logic [7:0] MAG_SPAN_FULL = 8'h05;
    localparam logic [7:0] MAG_SPAN_FAST = 8'h04;

    // ------------------------------------------------------------------
    // Control register layout
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sleep_rate;
        logic [2:0] output_rate_select;
        logic       low_noise_select;
        logic       fast_read;
        logic       active;
    } smrc_ctrl_s;

    // ------------------------------------------------------------------
    // Sample timing
    // ------------------------------------------------------------------
    // Every rate period is a whole multiple of the 1.25 ms base period.
    localparam int unsigned CLK_PERIOD_PS  = 20000;
    localparam int unsigned BASE_PERIOD_PS = 1250000000;
    localparam int unsigned BASE_CYCLES    = BASE_PERIOD_PS / CLK_PERIOD_PS;

    typedef logic [10:0] smrc_mult_t;

    // Base periods per output period, indexed by the output rate code.
    localparam smrc_mult_t ODR_MULT [8] = '{
        11'h001, 11'h002, 11'h004, 11'h008, 11'h010, 11'h040, 11'h080, 11'h200
    };
    // Base periods per sample while asleep: 50, 12.5, 6.25 and 1.56 Hz.
    localparam smrc_mult_t SLEEP_MULT [4] = '{11'h010, 11'h040, 11'h080, 11'h200};

endpackage

//--- logic/smrc_top.sv
// Mode/rate control register bank with identity register, sample tick and burst addressing.
`timescale 1ns/1ps
module smrc_top #(
    parameter int unsigned P_BASE_CYCLES = smrc_pkg::BASE_CYCLES,
    parameter logic [7:0]  P_IDENTITY    = 8'h5a, // Arbitrary identity value.
    parameter logic [7:0]  P_MAG_X_MSB   = 8'h33
) (
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rstn,
    // Register port
    input  wire logic [7:0]          i_reg_addr,
    input  wire logic                i_reg_wr,
    input  wire logic [7:0]          i_reg_wdata,
    input  wire logic                i_reg_rd,
    output logic [7:0]               o_reg_rdata,
    // System mode inputs
    input  wire logic                i_sleep,
    input  wire logic                i_hybrid,
    input  wire logic                i_hyb_autoinc,
    // Burst address stepping
    input  wire logic                i_burst_step,
    input  wire logic [7:0]          i_burst_addr,
    output logic [7:0]               o_burst_next,
    // Control outputs
    output smrc_pkg::smrc_ctrl_s     o_ctrl,
    output logic                     o_gain_x2,
    output logic                     o_range_limit_4g,
    output logic                     o_msb_only,
    output logic                     o_sample_tick
);

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    smrc_pkg::smrc_ctrl_s ctrl_q;
    smrc_pkg::smrc_ctrl_s ctrl_d;
    smrc_pkg::smrc_ctrl_s wr_ctrl;
    wire logic ctrl_sel = i_reg_addr == smrc_pkg::ADDR_MODE_RATE_CTRL;
    wire logic ctrl_wr  = i_reg_wr && ctrl_sel;

    // While active only the active bit may move; other fields hold so a running
    // measurement never sees its rate or gain change under it.
    assign wr_ctrl = smrc_pkg::smrc_ctrl_s'(i_reg_wdata);
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (ctrl_wr && !ctrl_q.active)
            ctrl_d = wr_ctrl;
        else if (ctrl_wr)
            ctrl_d.active = wr_ctrl.active;
    end

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            ctrl_q <= smrc_pkg::smrc_ctrl_s'(smrc_pkg::CTRL_RESET);
        else
            ctrl_q <= ctrl_d;
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire logic       id_sel = i_reg_addr == smrc_pkg::ADDR_DEVICE_IDENTITY;
    wire logic [7:0] rdata_d = id_sel   ? P_IDENTITY :
                               ctrl_sel ? 8'(ctrl_q) : smrc_pkg::RDATA_UNMAPPED;
    logic [7:0] rdata_q;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            rdata_q <= smrc_pkg::RDATA_UNMAPPED;
        else if (i_reg_rd)
            rdata_q <= rdata_d;
    end

    // ------------------------------------------------------------------
    // Sample tick
    // ------------------------------------------------------------------
    logic [31:0]         base_cnt_q;
    smrc_pkg::smrc_mult_t mult_cnt_q;
    logic                tick_q;
    wire logic base_tick = base_cnt_q == 32'(P_BASE_CYCLES - 1);
    wire smrc_pkg::smrc_mult_t rate_mult = i_sleep
        ? smrc_pkg::SLEEP_MULT[ctrl_q.sleep_rate]
        : smrc_pkg::ODR_MULT[ctrl_q.output_rate_select];
    wire smrc_pkg::smrc_mult_t period_mult = i_hybrid ? 11'(rate_mult << 1) : rate_mult;
    wire logic period_end = base_tick && (mult_cnt_q >= 11'(period_mult - 11'h001));

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            base_cnt_q <= '0;
            mult_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else if (!ctrl_q.active)
        begin
            base_cnt_q <= '0;
            mult_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else
        begin
            base_cnt_q <= base_tick ? '0 : base_cnt_q + 32'h1;
            mult_cnt_q <= period_end ? '0 : (base_tick ? mult_cnt_q + 11'h001 : mult_cnt_q);
            tick_q     <= period_end;
        end
    end

    // ------------------------------------------------------------------
    // Burst address auto-increment
    // ------------------------------------------------------------------
    // Fast read steps by two so only high bytes are visited; hybrid auto-increment
    // chains the acceleration block into the magnetic block and wraps back.
    wire logic       fast    = ctrl_q.fast_read;
    wire logic       chain   = i_hybrid && i_hyb_autoinc;
    wire logic [7:0] step    = fast ? smrc_pkg::ADDR_STEP_TWO : smrc_pkg::ADDR_STEP_ONE;
    wire logic [7:0] acc_end = fast ? smrc_pkg::ADDR_Z_MSB : smrc_pkg::ADDR_Z_LSB;
    wire logic [7:0] mag_end = P_MAG_X_MSB + (fast ? smrc_pkg::MAG_SPAN_FAST
                                                   : smrc_pkg::MAG_SPAN_FULL);
    wire logic [7:0] next_addr =
        (i_burst_addr == acc_end) ? (chain ? P_MAG_X_MSB : smrc_pkg::ADDR_X_MSB) :
        (chain && i_burst_addr == mag_end) ? smrc_pkg::ADDR_X_MSB :
        8'(i_burst_addr + step);
    logic [7:0] next_q;

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            next_q <= smrc_pkg::ADDR_X_MSB;
        else if (i_burst_step)
            next_q <= next_addr;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_reg_rdata      = rdata_q;
    assign o_burst_next     = next_q;
    assign o_ctrl           = ctrl_q;
    assign o_gain_x2        = ctrl_q.low_noise_select;
    assign o_range_limit_4g = ctrl_q.low_noise_select;
    assign o_msb_only       = ctrl_q.fast_read;
    assign o_sample_tick    = tick_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_id_read;
        @(posedge i_clk) disable iff (!i_rstn)
        i_reg_rd && i_reg_addr == smrc_pkg::ADDR_DEVICE_IDENTITY |=> o_reg_rdata == P_IDENTITY;
    endproperty
    a_id_read: assert property (p_id_read) else $error("identity read wrong");

    property p_active_write;
        @(posedge i_clk) disable iff (!i_rstn)
        i_reg_wr && ctrl_sel |=> o_ctrl.active == $past(i_reg_wdata[0]);
    endproperty
    a_active_write: assert property (p_active_write) else $error("active bit not written");

    property p_standby_quiet;
        @(posedge i_clk) disable iff (!i_rstn)
        !o_ctrl.active ##1 !o_ctrl.active |-> !o_sample_tick;
    endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("tick in standby");

    property p_active_hold;
        @(posedge i_clk) disable iff (!i_rstn)
        o_ctrl.active && i_reg_wr && ctrl_sel |=> o_ctrl[7:1] == $past(o_ctrl[7:1]);
    endproperty
    a_active_hold: assert property (p_active_hold) else $error("field changed while active");

    property p_gain_write;
        @(posedge i_clk) disable iff (!i_rstn)
        !o_ctrl.active && i_reg_wr && ctrl_sel |=> o_gain_x2 == $past(i_reg_wdata[2]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain not updated");

    property p_fast_skip;
        @(posedge i_clk) disable iff (!i_rstn)
        i_burst_step && o_msb_only && i_burst_addr == smrc_pkg::ADDR_X_MSB
        |=> o_burst_next == smrc_pkg::ADDR_Y_MSB;
    endproperty
    a_fast_skip: assert property (p_fast_skip) else $error("fast read did not skip");

    property p_fast_chain;
        @(posedge i_clk) disable iff (!i_rstn)
        i_burst_step && o_msb_only && i_hybrid && i_hyb_autoinc
        && i_burst_addr == smrc_pkg::ADDR_Z_MSB |=> o_burst_next == P_MAG_X_MSB;
    endproperty
    a_fast_chain: assert property (p_fast_chain) else $error("fast hybrid chain wrong");

    property p_full_chain;
        @(posedge i_clk) disable iff (!i_rstn)
        i_burst_step && !o_msb_only && i_hybrid && i_hyb_autoinc
        && i_burst_addr == smrc_pkg::ADDR_Z_LSB |=> o_burst_next == P_MAG_X_MSB;
    endproperty
    a_full_chain: assert property (p_full_chain) else $error("hybrid chain wrong");

    property p_tick_period;
        @(posedge i_clk) disable iff (!i_rstn)
        o_ctrl.active && base_tick && mult_cnt_q == 11'(period_mult - 11'h001)
        |=> o_sample_tick ##1 !o_sample_tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

    property p_cov_tick;
        @(posedge i_clk) disable iff (!i_rstn) o_sample_tick && i_sleep;
    endproperty
    c_cov_tick: cover property (p_cov_tick);

    property p_cov_hybrid_fast;
        @(posedge i_clk) disable iff (!i_rstn)
        i_burst_step && o_msb_only && chain && i_burst_addr == smrc_pkg::ADDR_Z_MSB;
    endproperty
    c_cov_hybrid_fast: cover property (p_cov_hybrid_fast);

    property p_cov_ignored;
        @(posedge i_clk) disable iff (!i_rstn)
        o_ctrl.active && ctrl_wr && i_reg_wdata[7:1] != o_ctrl[7:1];
    endproperty
    c_cov_ignored: cover property (p_cov_ignored);

endmodule

//--- dv/smrc_host.sv
// Host model that drives the register port of the mode/rate control block.
`timescale 1ns/1ps
module smrc_host (
    // Clock
    input  wire logic       i_clk,
    // Register port
    output logic [7:0]      o_addr,
    output logic            o_wr,
    output logic [7:0]      o_wdata,
    output logic            o_rd,
    input  wire logic [7:0] i_rdata
);
    // This host keeps the range at 2g/4g and the FIFO off.
    // Low-noise and fast-read may therefore be changed whenever the active bit is clear.
    initial
    begin
        o_addr  = 8'h00;
        o_wr    = 1'b0;
        o_wdata = 8'h00;
        o_rd    = 1'b0;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_addr  = a;
        o_wdata = d;
        o_wr    = 1'b1;
        @(negedge i_clk);
        o_wr    = 1'b0;
        // Released data is inverted so that a stale value cannot pass.
        o_wdata = ~d;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_rd   = 1'b1;
        @(negedge i_clk);
        o_rd   = 1'b0;
        d      = i_rdata;
    endtask
endmodule

//--- dv/test_sensor_mode_rate_control.sv
// Self-checking bench for the mode/rate control block.
`timescale 1ns/1ps
module test_sensor_mode_rate_control;
    localparam int unsigned BC   = 4;
    localparam logic [7:0]  ID   = 8'h5a; // Arbitrary identity value.
    localparam logic [7:0]  MAGX = 8'h33;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_sleep = 1'b0, i_hybrid = 1'b0;
    logic i_hyb_autoinc = 1'b0, i_burst_step = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, burst_next, rd, e;
    logic [7:0] burst_addr = 8'h01, m_ctrl = 8'h00;
    logic reg_wr, reg_rd, gain, lim, msb, tick;
    logic [31:0] rng = 32'hf179d6a9;
    smrc_pkg::smrc_ctrl_s ctrl;
    int failures = 0, checks_done = 0;
    int odr [8] = '{1, 2, 4, 8, 16, 64, 128, 512};
    int slp [4] = '{16, 64, 128, 512};

    smrc_host host (.i_clk(i_clk), .o_addr(reg_addr), .o_wr(reg_wr), .o_wdata(reg_wdata),
        .o_rd(reg_rd), .i_rdata(reg_rdata));
    smrc_top #(.P_BASE_CYCLES(BC), .P_IDENTITY(ID), .P_MAG_X_MSB(MAGX)) uut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
        .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
        .i_sleep(i_sleep), .i_hybrid(i_hybrid), .i_hyb_autoinc(i_hyb_autoinc),
        .i_burst_step(i_burst_step), .i_burst_addr(burst_addr), .o_burst_next(burst_next),
        .o_ctrl(ctrl), .o_gain_x2(gain), .o_range_limit_4g(lim), .o_msb_only(msb),
        .o_sample_tick(tick));

    initial
    begin
        forever #10 i_clk = ~i_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [7:0] nx(input logic [7:0] a, input logic f, input logic ch);
        if (a == (f ? 8'h05 : 8'h06)) return ch ? MAGX : 8'h01;
        if (a == MAGX + (f ? 8'h04 : 8'h05)) return 8'h01;
        return a + (f ? 8'h02 : 8'h01);
    endfunction

    task automatic stop_test;
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Writes through the host and follows the control register in the model.
    task automatic mw(input logic [7:0] a, input logic [7:0] d);
        host.wr_reg(a, d);
        if (a == 8'h2a) m_ctrl = m_ctrl[0] ? {m_ctrl[7:1], d[0]} : d;
        @(negedge i_clk);
        chk({ctrl, 5'h00, gain, lim, msb}, {m_ctrl, 5'h00, m_ctrl[2], m_ctrl[2], m_ctrl[1]});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] x);
        host.rd_reg(a, rd);
        chk({8'h00, rd}, {8'h00, x});
    endtask

    // Fields change only in standby; the active bit goes last.
    task automatic cfg(input logic [7:0] d);
        mw(8'h2a, 8'h00);
        mw(8'h2a, {d[7:1], 1'b0});
        mw(8'h2a, d);
    endtask

    task automatic tk(input int m);
        int n;
        n = 0;
        while (tick !== 1'b1 && n < 9000)
        begin
            @(negedge i_clk);
            n++;
        end
        // A tick that never shows up is a failure in its own right.
        if (n >= 9000)
        begin
            failures++;
            stop_test();
        end
        n = 0;
        do
        begin
            @(negedge i_clk);
            n++;
        end while (tick !== 1'b1 && n < 9000);
        chk(16'(n), 16'(m * BC));
        if (n >= 9000) stop_test();
    endtask

    initial
    begin
        repeat (5) @(negedge i_clk);
        i_rstn = 1'b1;
        chk({ctrl, burst_next}, 16'h0001);
        rdc(8'h2a, 8'h00);
        mw(8'h0d, 8'hff);
        rdc(8'h0d, ID);
        rdc(8'h77, 8'h00);
        repeat (20)
        begin
            rng = xs(rng);
            mw(8'h2a, {rng[7:1], 1'b0});
        end
        cfg(8'h19);
        mw(8'h2a, 8'hc7);
        mw(8'h2a, 8'hc6);
        rdc(8'h2a, m_ctrl);
        for (int h = 0; h < 2; h++)
        begin
            i_hybrid = h[0];
            for (int r = 0; r < 8; r++)
            begin
                cfg({2'b00, r[2:0], 3'b001});
                tk(odr[r] << h);
            end
            i_sleep = 1'b1;
            for (int r = 0; r < 4; r++)
            begin
                rng = xs(rng);
                cfg({r[1:0], rng[2:0], 3'b001});
                tk(slp[r] << h);
            end
            i_sleep = 1'b0;
        end
        for (int k = 0; k < 8; k++)
        begin
            i_hybrid = k[0];
            i_hyb_autoinc = k[1];
            cfg({6'h00, k[2], 1'b0});
            i_burst_step = 1'b1;
            repeat (14)
            begin
                e = nx(burst_addr, k[2], k[0] & k[1]);
                @(negedge i_clk);
                chk({8'h00, burst_next}, {8'h00, e});
                burst_addr = e;
            end
            i_burst_step = 1'b0;
            burst_addr = 8'h01;
        end
        stop_test();
    end
endmodule
